// ### scf_sync.sv
// three-stage pin input synchroniser of the command-frame block
// assumes one reference clock domain on the far side of every synchroniser
// reset level should equal the idle level of the pin, else a false edge follows reset

`timescale 1ns/1ps

module scf_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_LVL = '0
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_level
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } scf_sync_s;

  scf_sync_s q;
  scf_sync_s d;

  always_comb begin
    d = q;
    d.s1 = i_async;
    d.s2 = q.s1;
    d.s3 = q.s2;
    // a bit changes only once the second and third stages agree
    for (int i = 0; i < W; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        d.lvl[i] = q.s3[i];
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      q <= '{s1: RST_LVL, s2: RST_LVL, s3: RST_LVL, lvl: RST_LVL};
    end else begin
      q <= d;
    end
  end

  assign o_level = q.lvl;
endmodule

// ### scf_frame.sv
// 16-bit serial command/response frame logic of a multi-channel switch controller
// assumes: sclk idles low, si sampled on falling sclk, so changes on rising sclk,
// cs_n high at least 200 ns between frames and 200 ns lead before first sclk edge

`timescale 1ns/1ps

package scf_pkg;
  localparam int FRAME_BITS = 16;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 10;
  localparam int BANKS = 2;
  localparam int REGS = 16;
  localparam int CNT_W = 4;
  localparam int SW_W = 6;
  localparam int ERR_W = 4;
  localparam int OUT_ZERO_MSB = 9;
  localparam int OUT_ZERO_LSB = 6;
  localparam int ADDR_MSB = 13;
  localparam int ADDR_LSB = 10;
  localparam int DIAG_LIMP_BIT = 14;
  localparam int DIAG_BYPASS_BIT = 13;
  localparam int DIAG_CLK_BIT = 11;
  localparam int DIAG_CMD_BIT = 0;
  localparam logic OUT_BANK = 1'b0;
  localparam logic [3:0] OUT_ADDR = 4'h0;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [4:0] RISE_LAST = 5'h10;
  localparam logic [4:0] BIT_TOP = 5'h0f;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [9:0] DATA_ZERO = 10'h000;

  // bit layout of a 16-bit command frame, msb first
  typedef struct packed {
    logic wr;
    logic bank;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } scf_cmd_s;

  // one configuration write handed to the register banks
  typedef struct packed {
    logic bank;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } scf_cfg_s;

  typedef enum logic [0:0] {
    SCF_RSP_DIAG,
    SCF_RSP_READ
  } scf_rsp_e;
endpackage

module scf_frame #(
  parameter int N_SW = scf_pkg::SW_W,
  parameter int N_ERR = scf_pkg::ERR_W
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_si,
  output logic o_so,
  output logic o_so_oe,
  input wire logic i_limp_home_input_n,
  input wire logic i_bypass_monitor_flag,
  input wire logic i_clock_status_flag,
  input wire logic [N_ERR-1:0] i_channel_fault_flag,
  output logic [N_SW-1:0] o_channel_switch_bit,
  output logic o_transfer_error_flag,
  output logic o_cfg_wr_valid,
  output scf_pkg::scf_cfg_s o_cfg_wr
);
  // switch bits share the low data field with the zero-checked bits 9..6
  initial begin
    if (N_SW < 1 || N_SW > scf_pkg::OUT_ZERO_LSB) begin
      $error("scf_frame: unsupported switch channel count");
    end
    if (N_ERR < 1 || N_ERR > N_SW) begin
      $error("scf_frame: unsupported fault flag count");
    end
    // the frame check relies on the bit counter wrapping once per frame
    if ((1 << scf_pkg::CNT_W) != scf_pkg::FRAME_BITS) begin
      $error("scf_frame: bit counter does not match frame length");
    end
    if (scf_pkg::ADDR_MSB - scf_pkg::ADDR_LSB + 1 != scf_pkg::ADDR_W) begin
      $error("scf_frame: address field width mismatch");
    end
  end

  // link side, receive half: clocked on falling sclk, cleared by the core's rx_clr flop between frames
  typedef struct packed {
    logic [scf_pkg::FRAME_BITS-1:0] sh;
    logic [scf_pkg::CNT_W-1:0] cnt;
    logic got;
  } scf_rx_s;

  // link side, transmit half: clocked on rising sclk, cleared while cs_n is high
  typedef struct packed {
    logic [4:0] rise;
    logic so;
  } scf_tx_s;

  typedef struct packed {
    logic cs_prev;
    logic rx_clr;
    logic oe;
    logic transfer_error_flag;
    logic limp;
    scf_pkg::scf_rsp_e rsp;
    logic rsp_bank;
    logic [scf_pkg::ADDR_W-1:0] rsp_addr;
    logic [scf_pkg::FRAME_BITS-1:0] tx;
    logic [N_SW-1:0] sw;
    logic [scf_pkg::BANKS-1:0][scf_pkg::REGS-1:0][scf_pkg::DATA_W-1:0] cfg;
    logic cfg_wr;
    scf_pkg::scf_cfg_s cfg_out;
  } scf_core_s;

  scf_rx_s rx_q;
  scf_rx_s rx_d;
  scf_tx_s tx_q;
  scf_tx_s tx_d;
  scf_core_s q;
  scf_core_s d;
  logic link_clr;
  logic rx_rst;
  logic cs_n_sync;
  logic limp_sync;

  // transmit half is emptied by the frame signal itself, as sclk stops outside frames
  assign link_clr = i_reset | i_cs_n;
  // receive half must outlive the cs_n rise until the core has taken the word,
  // so a core flop that follows the synchronised frame edges empties it
  assign rx_rst = i_reset | q.rx_clr;

  scf_sync #(
    .W(1),
    .RST_LVL(1'b1)
  ) u_cs_sync (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_async(i_cs_n),
    .o_level(cs_n_sync)
  );

  scf_sync #(
    .W(1),
    .RST_LVL(1'b1)
  ) u_limp_sync (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_async(i_limp_home_input_n),
    .o_level(limp_sync)
  );

  always_comb begin
    rx_d = rx_q;
    rx_d.sh = {rx_q.sh[scf_pkg::FRAME_BITS-2:0], i_si};
    rx_d.cnt = rx_q.cnt + 4'h1;
    rx_d.got = 1'b1;
  end

  always_ff @(negedge i_sclk or posedge rx_rst) begin
    if (rx_rst) begin
      rx_q <= '0;
    end else begin
      rx_q <= rx_d;
    end
  end

  always_comb begin
    tx_d = tx_q;
    if (tx_q.rise != scf_pkg::RISE_LAST) begin
      tx_d.rise = tx_q.rise + 5'h01;
      // q.tx is settled well ahead of the first rising edge by the cs lead time
      tx_d.so = q.tx[4'(scf_pkg::BIT_TOP - tx_q.rise)];
    end else begin
      // past the sixteenth bit nothing further is offered
      tx_d.so = 1'b0;
    end
  end

  always_ff @(posedge i_sclk or posedge link_clr) begin
    if (link_clr) begin
      tx_q <= '0;
    end else begin
      tx_q <= tx_d;
    end
  end

  // standard diagnosis word; unlisted bits read 0
  function automatic logic [scf_pkg::FRAME_BITS-1:0] diag_word(
    input logic limp_n,
    input logic bypass,
    input logic clk_st,
    input logic [N_ERR-1:0] err
  );
    logic [scf_pkg::FRAME_BITS-1:0] w;
    w = scf_pkg::WORD_ZERO;
    w[scf_pkg::DIAG_LIMP_BIT] = ~limp_n;
    w[scf_pkg::DIAG_BYPASS_BIT] = bypass;
    w[scf_pkg::DIAG_CLK_BIT] = clk_st;
    // only internal channels have fault flags; the upper switch channels have none
    w[N_ERR-1:0] = err;
    return w;
  endfunction

  // read reply: bit 15 set, bank and address echoed, then data
  function automatic logic [scf_pkg::FRAME_BITS-1:0] read_word(
    input logic bank,
    input logic [scf_pkg::ADDR_W-1:0] addr,
    input logic [N_SW-1:0] sw,
    input logic [scf_pkg::DATA_W-1:0] data
  );
    logic [scf_pkg::FRAME_BITS-1:0] w;
    w = scf_pkg::WORD_ZERO;
    w[scf_pkg::FRAME_BITS-1] = 1'b1;
    w[scf_pkg::FRAME_BITS-2] = bank;
    w[scf_pkg::ADDR_MSB:scf_pkg::ADDR_LSB] = addr;
    if (bank == scf_pkg::OUT_BANK && addr == scf_pkg::OUT_ADDR) begin
      // switch register reads back with bits 9..6 zero
      w[N_SW-1:0] = sw;
    end else begin
      w[scf_pkg::DATA_W-1:0] = data;
    end
    return w;
  endfunction

  always_comb begin
    logic cs_fall;
    logic cs_rise;
    logic ok;
    scf_pkg::scf_cmd_s cmd;
    logic [scf_pkg::FRAME_BITS-1:0] diag;
    logic [scf_pkg::FRAME_BITS-1:0] rd;
    cs_fall = 1'b0;
    cs_rise = 1'b0;
    ok = 1'b0;
    cmd = '0;
    diag = scf_pkg::WORD_ZERO;
    rd = scf_pkg::WORD_ZERO;
    d = q;
    d.cfg_wr = 1'b0;
    d.cs_prev = cs_n_sync;
    cs_fall = q.cs_prev & ~cs_n_sync;
    cs_rise = ~q.cs_prev & cs_n_sync;

    // diagnosis word, captured at chip select fall for the whole frame
    diag = diag_word(limp_sync, i_bypass_monitor_flag, i_clock_status_flag,
      i_channel_fault_flag);
    rd = read_word(q.rsp_bank, q.rsp_addr, q.sw, q.cfg[q.rsp_bank][q.rsp_addr]);

    if (cs_fall) begin
      d.oe = 1'b1;
      // receiver released long before the first falling sclk, given the lead time
      d.rx_clr = 1'b0;
      d.limp = limp_sync;
      if (q.rsp == scf_pkg::SCF_RSP_READ) begin
        d.tx = rd;
      end else begin
        d.tx = diag;
      end
    end

    if (cs_rise) begin
      d.oe = 1'b0;
      // the rx half is frozen now: no sclk edges while cs_n is high,
      // and it is only emptied once this word has been taken
      d.rx_clr = 1'b1;
      ok = rx_q.got && (rx_q.cnt == scf_pkg::CNT_ZERO);
      d.transfer_error_flag = ~ok;
      d.rsp = scf_pkg::SCF_RSP_DIAG;
      cmd = scf_pkg::scf_cmd_s'(rx_q.sh);
      // executed here even when this frame carried a read reply
      if (ok) begin
        if (cmd.wr) begin
          if (cmd.bank == scf_pkg::OUT_BANK && cmd.addr == scf_pkg::OUT_ADDR) begin
            if (cmd.data[scf_pkg::OUT_ZERO_MSB:scf_pkg::OUT_ZERO_LSB] == 4'h0) begin
              d.sw = cmd.data[N_SW-1:0];
            end
          end else begin
            d.cfg[cmd.bank][cmd.addr] = cmd.data;
            d.cfg_wr = 1'b1;
            d.cfg_out = '{bank: cmd.bank, addr: cmd.addr, data: cmd.data};
          end
        end else if (!cmd.data[scf_pkg::DIAG_CMD_BIT]) begin
          d.rsp = scf_pkg::SCF_RSP_READ;
          d.rsp_bank = cmd.bank;
          d.rsp_addr = cmd.addr;
        end
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      q <= '0;
      q.cs_prev <= 1'b1;
      q.rx_clr <= 1'b1;
      q.transfer_error_flag <= 1'b1;
      q.rsp <= scf_pkg::SCF_RSP_DIAG;
    end else begin
      q <= d;
    end
  end

  // before the first rising edge the error flag leads the frame
  assign o_so = (tx_q.rise == 5'h00) ? q.transfer_error_flag : tx_q.so;
  assign o_so_oe = q.oe;
  assign o_channel_switch_bit = q.sw;
  assign o_transfer_error_flag = q.transfer_error_flag;
  assign o_cfg_wr_valid = q.cfg_wr;
  assign o_cfg_wr = q.cfg_out;
endmodule

// ### scf_frame_sva.sv
// checker for the command-frame block, sees its ports only
// assumes ref clock far faster than sclk, frames 200 ns apart
`timescale 1ns/1ps
module scf_frame_sva #(
  parameter int N_SW = 6,
  parameter int N_ERR = 4
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_si,
  input wire logic o_so,
  input wire logic o_so_oe,
  input wire logic i_limp_home_input_n,
  input wire logic i_bypass_monitor_flag,
  input wire logic i_clock_status_flag,
  input wire logic [N_ERR-1:0] i_channel_fault_flag,
  input wire logic [N_SW-1:0] o_channel_switch_bit,
  input wire logic o_transfer_error_flag,
  input wire logic o_cfg_wr_valid,
  input wire scf_pkg::scf_cfg_s o_cfg_wr
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  property p_oe_on; $fell(i_cs_n) |-> ##[1:6] o_so_oe; endproperty
  a_oe_on: assert property (p_oe_on) else $error("so not enabled");
  property p_oe_off; $rose(i_cs_n) |-> ##[1:6] !o_so_oe; endproperty
  a_oe_off: assert property (p_oe_off) else $error("so not released");
  // sclk cannot rise within 60 ns of the fall
  property p_ter_so; $fell(i_cs_n) |-> ##6 (o_so == o_transfer_error_flag); endproperty
  a_ter_so: assert property (p_ter_so) else $error("so not error flag");
  property p_ter_rst; $fell(i_reset) |-> o_transfer_error_flag; endproperty
  a_ter_rst: assert property (p_ter_rst) else $error("flag low after reset");
  property p_cfg_pulse; o_cfg_wr_valid |-> $past(i_cs_n, 3) ##1 !o_cfg_wr_valid; endproperty
  a_cfg_pulse: assert property (p_cfg_pulse) else $error("bad write pulse");
  property p_sw_cs; !$stable(o_channel_switch_bit) |-> $past(i_cs_n, 3); endproperty
  a_sw_cs: assert property (p_sw_cs) else $error("switch change in frame");
  property p_ter_hold; !i_cs_n && !$past(i_cs_n) |-> $stable(o_transfer_error_flag); endproperty
  a_ter_hold: assert property (p_ter_hold) else $error("flag moved in frame");
  property p_cfg_hold; !$stable(o_cfg_wr) |-> o_cfg_wr_valid; endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("write word moved");
endmodule

// ### scf_spi_master.sv
// behavioural spi master for the frame block
// assumes so is only valid while the device enables it
`timescale 1ns/1ps
module scf_spi_master (
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_si,
  input wire logic i_so,
  input wire logic i_so_oe
);
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_si = 1'b0;
  end
  // n rising edges; undriven so reads as unknown
  task automatic frame(input logic [15:0] w, input int n, output logic [15:0] r, output logic t);
    int k;
    r = 16'h0000;
    // keeps every pin edge off the ref clock's rising edges
    #1;
    o_cs_n = 1'b0;
    #250;
    t = i_so_oe ? i_so : 1'bx;
    for (k = 0; k < n; k++) begin
      o_sclk = 1'b1;
      o_si = w[15-(k%16)];
      #62.5;
      r = {r[14:0], (i_so_oe ? i_so : 1'bx)};
      o_sclk = 1'b0;
      #62.5;
    end
    #250;
    o_cs_n = 1'b1;
    o_si = 1'b0;
    #299;
  endtask
endmodule

// ### test_scf_frame.sv
// top bench: frame block, spi master model, bound checker
// assumes 100 MHz ref clock, sclk period 125 ns
`timescale 1ns/1ps
module test_scf_frame;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic limp_n = 1'b1;
  logic bypass = 1'b0;
  logic clk_st = 1'b0;
  logic [3:0] faults = 4'h0;
  logic sclk, cs_n, si, so, so_oe, transfer_error_flag, cfg_v, t;
  logic [5:0] sw;
  logic [15:0] r;
  scf_pkg::scf_cfg_s cfg, cfg_seen;
  int num_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  always #5 ref_clk = ~ref_clk;
  scf_frame dut_u (.i_ref_clk(ref_clk), .i_reset(reset), .i_sclk(sclk), .i_cs_n(cs_n),
    .i_si(si), .o_so(so), .o_so_oe(so_oe), .i_limp_home_input_n(limp_n),
    .i_bypass_monitor_flag(bypass), .i_clock_status_flag(clk_st),
    .i_channel_fault_flag(faults), .o_channel_switch_bit(sw), .o_transfer_error_flag(transfer_error_flag),
    .o_cfg_wr_valid(cfg_v), .o_cfg_wr(cfg));
  scf_spi_master m_u (.o_sclk(sclk), .o_cs_n(cs_n), .o_si(si), .i_so(so), .i_so_oe(so_oe));
  always @(posedge ref_clk) begin
    cycles++;
    if (cfg_v) cfg_seen <= cfg;
    if (cycles == 10000) begin
      num_errors++;
      complete_run();
    end
  end
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task f(input logic [15:0] w);
    m_u.frame(w, 16, r, t);
  endtask
  task complete_run;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task t_write;
    f(16'h8015);
    chk(t, 1);
    chk(sw, 16'h15);
    chk(transfer_error_flag, 0);
    $display("t_write done");
  endtask
  task t_diag;
    @(posedge ref_clk);
    faults <= 4'ha;
    bypass <= 1'b1;
    clk_st <= 1'b1;
    limp_n <= 1'b0;
    repeat (5) @(posedge ref_clk);
    f(16'h0001);
    chk(r, 16'h680a);
    chk(t, 0);
    @(posedge ref_clk);
    limp_n <= 1'b1;
    faults <= 4'h5;
    repeat (5) @(posedge ref_clk);
    f(16'h0001);
    chk(r, 16'h2805);
    $display("t_diag done");
  endtask
  task t_read;
    f(16'hc6a5);
    chk(r, 16'h2805);
    chk(cfg_seen, 16'h46a5);
    f(16'h4400);
    f(16'h802a);
    chk(r, 16'hc6a5);
    chk(sw, 16'h2a);
    f(16'h8555);
    f(16'h4400);
    f(16'h0400);
    chk(r, 16'hc6a5);
    f(16'h0000);
    chk(r, 16'h8555);
    f(16'h0001);
    chk(r, 16'h802a);
    $display("t_read done");
  endtask
  task t_bad;
    m_u.frame(16'h8000, 15, r, t);
    f(16'h0001);
    chk(t, 1);
    chk(sw, 16'h2a);
    chk(transfer_error_flag, 0);
    $display("t_bad done");
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (5) @(posedge ref_clk);
    t_write();
    t_diag();
    t_read();
    t_bad();
    complete_run();
  end
endmodule
bind scf_frame scf_frame_sva #(.N_SW(N_SW), .N_ERR(N_ERR)) sva_u (.i_ref_clk(i_ref_clk),
  .i_reset(i_reset), .i_sclk(i_sclk), .i_cs_n(i_cs_n), .i_si(i_si), .o_so(o_so),
  .o_so_oe(o_so_oe), .i_limp_home_input_n(i_limp_home_input_n),
  .i_bypass_monitor_flag(i_bypass_monitor_flag), .i_clock_status_flag(i_clock_status_flag),
  .i_channel_fault_flag(i_channel_fault_flag), .o_channel_switch_bit(o_channel_switch_bit),
  .o_transfer_error_flag(o_transfer_error_flag), .o_cfg_wr_valid(o_cfg_wr_valid),
  .o_cfg_wr(o_cfg_wr));
